// >>> tb_top.sv
// Self-checking bench for the TLP malformed and routing checker
`include "tmrc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic ing_valid_i, egr_valid_i;
   logic [1:0] ing_port_i, egr_port_i;
   logic [2:0] egr_tc_i, ing_malformed_o, egr_malformed_o, unsupported_o;
   tmrc_pkg::tmrc_hdr_t ing_hdr_i;
   int n_errors = 0;
   int num_checks = 0;
   logic [31:0] q;
   logic [7:0] codes [10] = '{`TMRC_MSG_UNLOCK, `TMRC_MSG_PM_NAK, `TMRC_MSG_PME,
      `TMRC_MSG_PME_OFF, `TMRC_MSG_PME_TO_ACK, `TMRC_MSG_ERR_COR, `TMRC_MSG_ERR_NF,
      `TMRC_MSG_ERR_FAT, `TMRC_MSG_SPL, 8'h20};
   always #20 clk_i = ~clk_i;
   tmrc_checker dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ing_valid_i(ing_valid_i),
      .ing_port_i(ing_port_i), .ing_hdr_i(ing_hdr_i), .egr_valid_i(egr_valid_i),
      .egr_port_i(egr_port_i), .egr_tc_i(egr_tc_i), .ing_malformed_o(ing_malformed_o),
      .egr_malformed_o(egr_malformed_o), .unsupported_o(unsupported_o));
   tmrc_link_model src (.clk_i(clk_i), .ing_valid_o(ing_valid_i), .ing_port_o(ing_port_i),
      .ing_hdr_o(ing_hdr_i), .egr_valid_o(egr_valid_i), .egr_port_o(egr_port_i),
      .egr_tc_o(egr_tc_i));
   // ----------------------------------------------------------------
   // Access tasks and comparisons
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (e !== g) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [5:0] ix, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {ix, 2'b00};
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
   endtask
   function automatic tmrc_pkg::tmrc_hdr_t hd(input logic [4:0] t, input logic [2:0] tc,
      input logic [1:0] a, input logic [9:0] l, input logic [3:0] be, input logic [7:0] c,
      input logic [1:0] d, input logic [3:0] f);
      tmrc_pkg::tmrc_hdr_t h;
      h.fmt = t[4] ? 2'h1 : 2'h0;
      h.typ = t;
      h.tc = tc;
      h.attr = a;
      h.len = l;
      h.last_be = be;
      h.msg_code = c;
      h.dest_port = d;
      {h.trusted_cfg, h.up_range_hit, h.down_range_hit, h.vga_route} = f;
      return h;
   endfunction
   // Well-formed request; f packs trusted, upstream hit, downstream hit, VGA route
   function automatic tmrc_pkg::tmrc_hdr_t mm(input logic [4:0] t, input logic [2:0] tc,
      input logic [1:0] d, input logic [3:0] f);
      return hd(t, tc, 2'h0, `TMRC_LEN_ONE, 4'h0, 8'h00, d, f);
   endfunction
   function automatic tmrc_pkg::tmrc_hdr_t mg(input logic [2:0] r, input logic [7:0] c,
      input logic [2:0] tc);
      return hd({2'b10, r}, tc, 2'h0, 10'h000, 4'h0, c, 2'h0, 4'h0);
   endfunction
   // e holds the expected unsupported and malformed flags of port p
   task automatic tlp(input logic [1:0] p, input tmrc_pkg::tmrc_hdr_t h, input logic [1:0] e);
      logic [2:0] b;
      b = (p == 2'h3) ? 3'h0 : 3'h1 << p;
      src.send(p, h);
      @(negedge clk_i);
      chk("ing_malformed_o", {29'h0, e[0] ? b : 3'h0}, {29'h0, ing_malformed_o});
      chk("unsupported_o", {29'h0, e[1] ? b : 3'h0}, {29'h0, unsupported_o});
      @(negedge clk_i);
      chk("pulse_end", 32'h0, {26'h0, ing_malformed_o, unsupported_o});
   endtask
   task automatic eg(input logic [1:0] p, input logic [2:0] tc, input logic e);
      src.egr(p, tc);
      @(negedge clk_i);
      chk("egr_malformed_o", {29'h0, e ? 3'h1 << p : 3'h0}, {29'h0, egr_malformed_o});
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_i);
      n_errors++;
      test_done();
   end
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         wb(1'b0, i[5:0], 32'h0);
         chk("ctrl_reset", {20'h0, `TMRC_CTL_RESET}, q);
      end
      wb(1'b0, 6'h03, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1'b1, `TMRC_ADR_CTRL0, 32'h40F);
      wb(1'b1, `TMRC_ADR_CTRL1, 32'h70F);
      wb(1'b1, `TMRC_ADR_CTRL2, 32'hC0F);
      $display("test registers done");
      tlp(0, mm(5'h00, 0, 1, 6), 0);
      tlp(1, hd(`TMRC_TYP_IO, 0, 0, 10'h002, 0, 0, 0, 0), 1);
      wb(1'b0, `TMRC_ADR_STATUS, 32'h0);
      chk("status", 32'h2, q);
      wb(1'b0, `TMRC_ADR_COUNT, 32'h0);
      chk("count", 32'h0000_0001, q);
      wb(1'b1, `TMRC_ADR_STATUS, 32'h77);
      wb(1'b0, `TMRC_ADR_STATUS, 32'h0);
      chk("status_clear", 32'h0, q);
      for (int k = 0; k < 2; k++) begin
         tlp(0, mm(k ? `TMRC_TYP_CFG0 : `TMRC_TYP_IO, 0, 1, 6), 0);
         for (int i = 0; i < 4; i++) begin
            tlp(0, hd(k ? `TMRC_TYP_CFG0 : `TMRC_TYP_IO, i == 1, i == 2, (i == 0) ? 2 : 1,
               i == 3, 0, 1, 6), 1);
         end
      end
      for (int i = 0; i < 10; i++) begin
         tlp(1, mg(3'h4, codes[i], 3'h1), 1);
         tlp(1, mg(3'h4, codes[i], 3'h0), 0);
      end
      tlp(0, mg(3'h0, `TMRC_MSG_ERR_COR, 0), 1);
      tlp(1, mg(3'h0, `TMRC_MSG_ERR_COR, 0), 0);
      tlp(1, mg(3'h3, `TMRC_MSG_PME_OFF, 0), 1);
      tlp(0, mg(3'h3, `TMRC_MSG_PME_OFF, 0), 0);
      tlp(1, mg(3'h5, `TMRC_MSG_PME_TO_ACK, 0), 0);
      tlp(0, mg(3'h5, `TMRC_MSG_PME_TO_ACK, 0), 1);
      tlp(1, mg(3'h5, `TMRC_MSG_PM_NAK, 0), 1);
      tlp(0, mg(3'h4, 8'h20, 0), 1);
      tlp(2, mm(`TMRC_TYP_CFG1, 0, 0, 8), 1);
      tlp(0, mm(`TMRC_TYP_CFG1, 0, 0, 8), 0);
      tlp(0, mm(5'h00, 4, 1, 6), 1);
      tlp(3, mm(5'h00, 4, 1, 6), 0);
      $display("test malformed done");
      tlp(1, mm(5'h00, 0, 1, 0), 2);
      tlp(0, mm(5'h00, 0, 1, 4), 2);
      tlp(0, mm(5'h00, 0, 2, 6), 2);
      tlp(0, mm(`TMRC_TYP_IO, 0, 2, 6), 2);
      tlp(2, mm(5'h00, 0, 1, 1), 2);
      tlp(2, mm(5'h00, 0, 1, 0), 0);
      tlp(1, mm(`TMRC_TYP_CFG0, 0, 0, 0), 2);
      tlp(0, mm(`TMRC_TYP_CFG0, 0, 0, 0), 0);
      tlp(1, mm(`TMRC_TYP_CFG0, 1, 0, 0), 1);
      tlp(1, mm(5'h00, 0, 0, 0), 0);
      wb(1'b1, `TMRC_ADR_CTRL0, 32'h00F);
      tlp(1, mm(5'h00, 0, 0, 0), 2);
      wb(1'b1, `TMRC_ADR_CTRL0, 32'h40F);
      wb(1'b1, `TMRC_ADR_CTRL1, 32'h30F);
      tlp(1, mm(5'h00, 0, 0, 0), 2);
      $display("test routing done");
      for (int t = 0; t < 8; t++) begin
         eg(2, t[2:0], t >= 4);
      end
      eg(3, 3'h7, 0);
      wb(1'b1, `TMRC_ADR_CTRL2, 32'hCFF);
      tlp(2, mm(5'h00, 4, 1, 0), 0);
      tlp(0, mm(5'h00, 4, 1, 6), 1);
      eg(2, 3'h4, 0);
      eg(1, 3'h4, 1);
      $display("test maps done");
      test_done();
   end
endmodule
`default_nettype wire

// >>> tmrc_checker.sv
// TLP malformed and routing checker for a three port switch
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`include "tmrc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tmrc_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ing_valid_i,
   input wire logic [1:0] ing_port_i,
   input wire tmrc_pkg::tmrc_hdr_t ing_hdr_i,
   input wire logic egr_valid_i,
   input wire logic [1:0] egr_port_i,
   input wire logic [2:0] egr_tc_i,
   output logic [2:0] ing_malformed_o,
   output logic [2:0] egr_malformed_o,
   output logic [2:0] unsupported_o
);

   // ----------------------------------------------------------------
   // Per port control: class_to_channel_map, enables
   // ----------------------------------------------------------------
   logic [`TMRC_CTL_WIDTH-1:0] ctrl [`TMRC_NPORTS];
   logic [6:0] status;
   logic [15:0] mal_count;
   logic [15:0] ur_count;

   // ----------------------------------------------------------------
   // Wishbone decode
   // ----------------------------------------------------------------
   wire logic [5:0] wb_idx = wb_adr_i[7:2];
   wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Writes land at the edge where the master samples ack high
   wire logic wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
   wire logic sel_status = (wb_idx == `TMRC_ADR_STATUS);
   wire logic sel_count = (wb_idx == `TMRC_ADR_COUNT);
   wire logic [6:0] sts_clr = (wb_wr && sel_status && wb_sel_i[0]) ? wb_dat_i[6:0] : 7'h00;
   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (wb_idx)
         `TMRC_ADR_CTRL0: next_rdata = {20'h00000, ctrl[0]};
         `TMRC_ADR_CTRL1: next_rdata = {20'h00000, ctrl[1]};
         `TMRC_ADR_CTRL2: next_rdata = {20'h00000, ctrl[2]};
         `TMRC_ADR_STATUS: next_rdata = {25'h0000000, status};
         `TMRC_ADR_COUNT: next_rdata = {ur_count, mal_count};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Every access is answered one cycle later; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Ingress header decode
   // ----------------------------------------------------------------
   tmrc_pkg::tmrc_route_t msg_route;
   assign msg_route = tmrc_pkg::tmrc_route_t'(ing_hdr_i.typ[2:0]);

   wire logic in_ok = (ing_port_i < 2'h3);
   wire logic [1:0] in_idx = in_ok ? ing_port_i : `TMRC_UP_PORT;
   wire logic from_up = (ing_port_i == `TMRC_UP_PORT);
   wire logic chk = ing_valid_i && in_ok;
   wire logic is_mem = (ing_hdr_i.typ[4:1] == 4'h0);
   wire logic is_io = (ing_hdr_i.typ == `TMRC_TYP_IO);
   wire logic is_cfg0 = (ing_hdr_i.typ == `TMRC_TYP_CFG0);
   wire logic is_cfg = is_cfg0 || (ing_hdr_i.typ == `TMRC_TYP_CFG1);
   wire logic is_msg = (ing_hdr_i.typ[4:3] == 2'h2);
   wire logic [7:0] code = ing_hdr_i.msg_code;
   wire logic is_intx = is_msg && (code[7:3] == `TMRC_MSG_INTX_HI);
   wire logic is_pm = (code == `TMRC_MSG_PM_NAK) || (code == `TMRC_MSG_PME)
      || (code == `TMRC_MSG_PME_OFF) || (code == `TMRC_MSG_PME_TO_ACK);
   wire logic is_err = (code == `TMRC_MSG_ERR_COR) || (code == `TMRC_MSG_ERR_NF)
      || (code == `TMRC_MSG_ERR_FAT);
   wire logic tc0_msg = is_msg && (is_intx || is_pm || is_err
      || (code == `TMRC_MSG_UNLOCK) || (code == `TMRC_MSG_SPL));
   wire logic tc_nz = (ing_hdr_i.tc != 3'h0);
   // Shared shape test for I/O and configuration requests
   wire logic bad_shape = (ing_hdr_i.len != `TMRC_LEN_ONE) || tc_nz
      || (ing_hdr_i.attr != 2'h0) || (ing_hdr_i.last_be != 4'h0);

   // ----------------------------------------------------------------
   // Malformed checks at ingress
   // ----------------------------------------------------------------
   wire logic mal_io = is_io && bad_shape;
   wire logic mal_cfg = is_cfg && bad_shape;
   wire logic mal_msg_tc = tc0_msg && tc_nz;
   wire logic mal_to_rc = is_msg && (msg_route == tmrc_pkg::tmrc_rt_to_rc) && from_up;
   wire logic mal_bcast = is_msg && (msg_route == tmrc_pkg::tmrc_rt_bcast) && !from_up;
   wire logic mal_gath = is_msg && (msg_route == tmrc_pkg::tmrc_rt_gather)
      && (from_up || (code != `TMRC_MSG_PME_TO_ACK));
   wire logic mal_intx = is_intx && from_up;
   wire logic mal_trust = ing_hdr_i.trusted_cfg && !from_up;
   // The receiving port's own map decides, not the destination's
   wire logic [7:0] in_map = ctrl[in_idx][`TMRC_CTL_MAP_LSB +: 8];
   wire logic mal_map = !in_map[ing_hdr_i.tc];
   wire logic any_mal = mal_io || mal_cfg || mal_msg_tc || mal_to_rc || mal_bcast
      || mal_gath || mal_intx || mal_trust || mal_map;

   // ----------------------------------------------------------------
   // Routing checks, reported as unsupported requests
   // ----------------------------------------------------------------
   wire logic addr_rt = is_mem || is_io;
   wire logic [1:0] dest = ing_hdr_i.dest_port;
   wire logic dest_ok = (dest < 2'h3);
   wire logic [1:0] dest_idx = dest_ok ? dest : `TMRC_UP_PORT;
   wire logic dest_down = dest_ok && (dest != `TMRC_UP_PORT);
   wire logic ur_back = addr_rt && (dest == ing_port_i);
   wire logic ur_nohit = from_up && ing_hdr_i.up_range_hit && !ing_hdr_i.down_range_hit;
   wire logic ur_mae = is_mem && dest_down && !ctrl[dest_idx][`TMRC_CTL_MAE];
   wire logic ur_io_access_enable = is_io && dest_down && !ctrl[dest_idx][`TMRC_CTL_IO_ACCESS_ENABLE];
   wire logic ur_up_bme = addr_rt && !from_up && (dest == `TMRC_UP_PORT)
      && !ctrl[0][`TMRC_CTL_BME];
   wire logic ur_own_bme = addr_rt && !from_up && !ctrl[in_idx][`TMRC_CTL_BME];
   wire logic ur_vga = ing_hdr_i.vga_route && !from_up && ctrl[in_idx][`TMRC_CTL_VGA];
   wire logic ur_cfg0 = is_cfg0 && !from_up;
   // A malformed TLP is reported only as malformed, never also as unsupported
   wire logic any_ur = !any_mal && (ur_back || ur_nohit || ur_mae || ur_io_access_enable
      || ur_up_bme || ur_own_bme || ur_vga || ur_cfg0);

   // ----------------------------------------------------------------
   // Egress check against the leaving port's map
   // ----------------------------------------------------------------
   wire logic eg_ok = (egr_port_i < 2'h3);
   wire logic [1:0] eg_idx = eg_ok ? egr_port_i : `TMRC_UP_PORT;
   wire logic [7:0] eg_map = ctrl[eg_idx][`TMRC_CTL_MAP_LSB +: 8];
   wire logic eg_mal = egr_valid_i && eg_ok && !eg_map[egr_tc_i];

   // ----------------------------------------------------------------
   // Per port pulses, control and status bits
   // ----------------------------------------------------------------
   logic [2:0] next_ing_mal;
   logic [2:0] next_egr_mal;
   logic [2:0] next_ur;

   genvar p;
   generate
      for (p = 0; p < `TMRC_NPORTS; p = p + 1) begin : g_port
         wire logic wr_ctl = wb_wr && (wb_idx == 6'(p));
         wire logic [`TMRC_CTL_WIDTH-1:0] wmask = {{4{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
         assign next_ing_mal[p] = chk && (ing_port_i == 2'(p)) && any_mal;
         assign next_egr_mal[p] = eg_mal && (egr_port_i == 2'(p));
         assign next_ur[p] = chk && (ing_port_i == 2'(p)) && any_ur;

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               ctrl[p] <= `TMRC_CTL_RESET;
            end else if (wr_ctl) begin
               ctrl[p] <= (ctrl[p] & ~wmask) | (wb_dat_i[`TMRC_CTL_WIDTH-1:0] & wmask);
            end
         end

         // Sticky flags: a new event in the clear cycle survives
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               status[p] <= 1'b0;
               status[`TMRC_STS_UR_LSB + p] <= 1'b0;
            end else begin
               status[p] <= (status[p] && !sts_clr[p])
                  || next_ing_mal[p] || next_egr_mal[p];
               status[`TMRC_STS_UR_LSB + p] <= (status[`TMRC_STS_UR_LSB + p]
                  && !sts_clr[`TMRC_STS_UR_LSB + p]) || next_ur[p];
            end
         end
      end
   endgenerate

   // Unused status bit between the two groups reads as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status[3] <= 1'b0;
      end else begin
         status[3] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Output pulses and saturating event counters
   // ----------------------------------------------------------------
   wire logic mal_evt = (|next_ing_mal) || (|next_egr_mal);
   wire logic ur_evt = |next_ur;

   // Counters count cycles with an event; they saturate rather than wrap
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ing_malformed_o <= 3'h0;
         egr_malformed_o <= 3'h0;
         unsupported_o <= 3'h0;
         mal_count <= 16'h0000;
         ur_count <= 16'h0000;
      end else begin
         ing_malformed_o <= next_ing_mal;
         egr_malformed_o <= next_egr_mal;
         unsupported_o <= next_ur;
         if (mal_evt && mal_count != `TMRC_CNT_MAX) begin
            mal_count <= mal_count + 16'h0001;
         end
         if (ur_evt && ur_count != `TMRC_CNT_MAX) begin
            ur_count <= ur_count + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_io_shape_mal: assert property (chk && is_io && ing_hdr_i.len != `TMRC_LEN_ONE
      |=> |ing_malformed_o) else $error("bad io length not malformed");
   a_cfg_be_mal: assert property (chk && is_cfg && ing_hdr_i.last_be != 4'h0
      |=> |ing_malformed_o) else $error("bad cfg be not malformed");
   a_msg_tc_mal: assert property (chk && tc0_msg && tc_nz
      |=> |ing_malformed_o) else $error("message tc not zero missed");
   a_rc_on_up: assert property (chk && from_up && is_msg
      && msg_route == tmrc_pkg::tmrc_rt_to_rc |=> ing_malformed_o[0])
      else $error("route to rc on upstream missed");
   a_gather_ok: assert property (chk && !from_up && !mal_map && tmrc_pkg::tmrc_rt_gather == msg_route
      && is_msg && code == `TMRC_MSG_PME_TO_ACK && !tc_nz |=> ing_malformed_o == 3'h0)
      else $error("legal pme ack flagged");
   a_map_ingress: assert property (chk && !in_map[ing_hdr_i.tc]
      |=> |ing_malformed_o && unsupported_o == 3'h0) else $error("unmapped tc missed");
   a_map_egress: assert property (egr_valid_i && eg_ok && !eg_map[egr_tc_i]
      |=> egr_malformed_o[$past(eg_idx)]) else $error("egress unmapped tc missed");
   a_cfg0_down_ur: assert property (chk && !from_up && is_cfg0 && !any_mal
      |=> unsupported_o[$past(in_idx)]) else $error("type 0 on downstream not ur");
   a_back_route: assert property (chk && ur_back && !any_mal
      |=> |unsupported_o) else $error("route back not ur");
   a_pulse_one: assert property (|unsupported_o |=> unsupported_o != $past(unsupported_o)
      || $past(ur_evt)) else $error("ur pulse stretched");
   a_excl_flags: assert property (!(|(ing_malformed_o & unsupported_o)))
      else $error("malformed and ur together");
   a_sticky_set: assert property (ing_malformed_o[1] |-> status[1])
      else $error("status missed malformed event");
   a_wb_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");

   // ----------------------------------------------------------------
   // Further malformed checks
   // ----------------------------------------------------------------
   a_io_tc_mal: assert property (chk && is_io && tc_nz
      |=> |ing_malformed_o)
      else $error("io tc not zero missed");

   a_cfg_attr_mal: assert property (chk && is_cfg && ing_hdr_i.attr != 2'h0
      |=> |ing_malformed_o)
      else $error("cfg attr not zero missed");

   a_bcast_down: assert property (chk && !from_up && is_msg
      && msg_route == tmrc_pkg::tmrc_rt_bcast |=> ing_malformed_o[$past(in_idx)])
      else $error("broadcast on downstream missed");

   a_gather_up: assert property (chk && from_up && is_msg
      && msg_route == tmrc_pkg::tmrc_rt_gather |=> ing_malformed_o[0])
      else $error("gathered on upstream missed");

   a_intx_up: assert property (chk && from_up && is_intx
      |=> ing_malformed_o[0])
      else $error("intx on upstream missed");

   a_trust_down: assert property (chk && !from_up && ing_hdr_i.trusted_cfg
      |=> ing_malformed_o[$past(in_idx)])
      else $error("trusted cfg on downstream missed");

   // ----------------------------------------------------------------
   // Further routing checks
   // ----------------------------------------------------------------
   a_nohit_ur: assert property (chk && from_up && ing_hdr_i.up_range_hit
      && !ing_hdr_i.down_range_hit && !any_mal |=> unsupported_o[0])
      else $error("upstream range miss not ur");

   a_mae_ur: assert property (chk && is_mem && dest_down
      && !ctrl[dest_idx][`TMRC_CTL_MAE] && !any_mal |=> |unsupported_o)
      else $error("memory enable clear not ur");

   a_io_access_enable_ur: assert property (chk && is_io && dest_down
      && !ctrl[dest_idx][`TMRC_CTL_IO_ACCESS_ENABLE] && !any_mal |=> |unsupported_o)
      else $error("io enable clear not ur");

   a_up_bme_ur: assert property (chk && addr_rt && !from_up && dest == `TMRC_UP_PORT
      && !ctrl[0][`TMRC_CTL_BME] && !any_mal |=> unsupported_o[$past(in_idx)])
      else $error("upstream bus master clear not ur");

   a_own_bme_ur: assert property (chk && addr_rt && !from_up
      && !ctrl[in_idx][`TMRC_CTL_BME] && !any_mal |=> unsupported_o[$past(in_idx)])
      else $error("own bus master clear not ur");

   a_vga_ur: assert property (chk && ing_hdr_i.vga_route && !from_up
      && ctrl[in_idx][`TMRC_CTL_VGA] && !any_mal |=> unsupported_o[$past(in_idx)])
      else $error("vga route not ur");

   a_status_ur: assert property (|unsupported_o
      |-> |status[6:4])
      else $error("ur not recorded in status");

   // ----------------------------------------------------------------
   // Quiet outputs, bus and counters
   // ----------------------------------------------------------------
   a_idle_quiet: assert property (!ing_valid_i
      |=> ing_malformed_o == 3'h0 && unsupported_o == 3'h0)
      else $error("ingress pulse without tlp");

   a_port3_quiet: assert property (ing_valid_i && !in_ok
      |=> ing_malformed_o == 3'h0 && unsupported_o == 3'h0)
      else $error("ignored port raised a pulse");

   a_egr_idle: assert property (!egr_valid_i
      |=> egr_malformed_o == 3'h0)
      else $error("egress pulse without tlp");

   a_egr_mapped: assert property (egr_valid_i && eg_ok && eg_map[egr_tc_i]
      |=> egr_malformed_o == 3'h0)
      else $error("mapped egress tc flagged");

   a_ack_follows: assert property (wb_req
      |=> wb_ack_o)
      else $error("bus request not acked");

   a_sts_clear: assert property (wb_wr && sel_status && wb_sel_i[0] && wb_dat_i[0]
      && !next_ing_mal[0] && !next_egr_mal[0] |=> !status[0])
      else $error("status clear ignored");

   a_count_sat: assert property (mal_count == `TMRC_CNT_MAX
      |=> mal_count == `TMRC_CNT_MAX)
      else $error("malformed count wrapped");

   c_mal_io: cover property (chk && mal_io ##1 |ing_malformed_o);
   c_ur_mae: cover property (chk && ur_mae && !any_mal ##1 |unsupported_o);
   c_egress: cover property (|egr_malformed_o);
   c_clear_set: cover property (wb_wr && sel_status && |next_ur);
   c_gather_ok: cover property (chk && !from_up && is_msg && msg_route == tmrc_pkg::tmrc_rt_gather);

endmodule

`default_nettype wire

// >>> tmrc_defs.svh
// Constants for the TLP malformed and routing checker
`ifndef TMRC_DEFS_SVH
`define TMRC_DEFS_SVH
// ----------------------------------------------------------------
// Ports
// ----------------------------------------------------------------
`define TMRC_NPORTS 3
`define TMRC_UP_PORT 2'h0
// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define TMRC_ADR_CTRL0 6'h00
`define TMRC_ADR_CTRL1 6'h01
`define TMRC_ADR_CTRL2 6'h02
`define TMRC_ADR_STATUS 6'h04
`define TMRC_ADR_COUNT 6'h05
`define TMRC_CTL_MAP_LSB 0
`define TMRC_CTL_MAE 8
`define TMRC_CTL_IO_ACCESS_ENABLE 9
`define TMRC_CTL_BME 10
`define TMRC_CTL_VGA 11
`define TMRC_CTL_WIDTH 12
`define TMRC_CTL_RESET 12'h001
`define TMRC_STS_UR_LSB 4
`define TMRC_CNT_MAX 16'hFFFF
// ----------------------------------------------------------------
// TLP type codes and message codes
// ----------------------------------------------------------------
`define TMRC_TYP_IO 5'h02
`define TMRC_TYP_CFG0 5'h04
`define TMRC_TYP_CFG1 5'h05
`define TMRC_LEN_ONE 10'h001
`define TMRC_MSG_UNLOCK 8'h00
`define TMRC_MSG_PM_NAK 8'h14
`define TMRC_MSG_PME 8'h18
`define TMRC_MSG_PME_OFF 8'h19
`define TMRC_MSG_PME_TO_ACK 8'h1B
`define TMRC_MSG_INTX_HI 5'h04
`define TMRC_MSG_ERR_COR 8'h30
`define TMRC_MSG_ERR_NF 8'h31
`define TMRC_MSG_ERR_FAT 8'h33
`define TMRC_MSG_SPL 8'h50
`endif

// >>> tmrc_link_model.sv
// Link-side model that presents ingress and egress TLPs to the checker
`timescale 1ns/1ps
`default_nettype none
module tmrc_link_model (
   input wire logic clk_i,
   output logic ing_valid_o,
   output logic [1:0] ing_port_o,
   output tmrc_pkg::tmrc_hdr_t ing_hdr_o,
   output logic egr_valid_o,
   output logic [1:0] egr_port_o,
   output logic [2:0] egr_tc_o
);
   // ----------------------------------------------------------------
   // One TLP per call, launched just after a rising edge
   // ----------------------------------------------------------------
   initial begin
      ing_valid_o = 1'b0;
      ing_port_o = 2'h0;
      ing_hdr_o = '0;
      egr_valid_o = 1'b0;
      egr_port_o = 2'h0;
      egr_tc_o = 3'h0;
   end
   task automatic send(input logic [1:0] p, input tmrc_pkg::tmrc_hdr_t h);
      @(posedge clk_i);
      ing_valid_o <= 1'b1;
      ing_port_o <= p;
      ing_hdr_o <= h;
      @(posedge clk_i);
      ing_valid_o <= 1'b0;
      // Idle lines carry junk, never the previous header
      ing_hdr_o <= ~h;
      ing_port_o <= ~p;
   endtask
   task automatic egr(input logic [1:0] p, input logic [2:0] tc);
      @(posedge clk_i);
      egr_valid_o <= 1'b1;
      egr_port_o <= p;
      egr_tc_o <= tc;
      @(posedge clk_i);
      egr_valid_o <= 1'b0;
      egr_tc_o <= ~tc;
   endtask
endmodule
`default_nettype wire

// >>> tmrc_pkg.sv
// Types shared by the TLP malformed and routing checker
package tmrc_pkg;
   // Implicit message routing carried in the low type bits
   typedef enum logic [2:0] {
      tmrc_rt_to_rc = 3'h0,
      tmrc_rt_by_addr = 3'h1,
      tmrc_rt_by_id = 3'h2,
      tmrc_rt_bcast = 3'h3,
      tmrc_rt_local = 3'h4,
      tmrc_rt_gather = 3'h5,
      tmrc_rt_res6 = 3'h6,
      tmrc_rt_res7 = 3'h7
   } tmrc_route_t;

   // Header fields plus the address decoder's verdict for one TLP
   typedef struct packed {
      logic [1:0] fmt;
      logic [4:0] typ;
      logic [2:0] tc;
      logic [1:0] attr;
      logic [9:0] len;
      logic [3:0] last_be;
      logic [7:0] msg_code;
      logic trusted_cfg;
      logic [1:0] dest_port;
      logic up_range_hit;
      logic down_range_hit;
      logic vga_route;
   } tmrc_hdr_t;
endpackage
